/* File: src/asb_pkg.sv */
package asb_pkg;
	localparam int ASB_AW = 4;
	localparam int ASB_DW = 16;
	localparam int ASB_SAMPLE_W = 12;
	localparam int ASB_BUF_AW = 16;
	localparam int ASB_BUF_WORDS = 65536;
	localparam int ASB_BLK_W = 4;
	localparam int ASB_RATE_W = 4;
	localparam int ASB_GAIN_W = 3;
	localparam int ASB_WIN_AW = 17;
	localparam int ASB_WIN_BASE_W = 15;

	localparam logic [3:0] ASB_OFF_BCSW = 4'h0;
	localparam logic [3:0] ASB_OFF_ISCW = 4'h1;
	localparam logic [3:0] ASB_OFF_OSCW = 4'h2;
	localparam logic [3:0] ASB_OFF_STAT = 4'h3;

	localparam int ASB_CSR_BUFSEL = 0;
	localparam int ASB_CSR_BUFEN = 1;
	localparam int ASB_CSR_ONLINE = 2;
	localparam int ASB_CSR_IRQEN = 3;
	localparam int ASB_CSR_IRUN = 4;
	localparam int ASB_CSR_ORUN = 5;
	localparam int ASB_CSR_MASTER = 6;
	localparam int ASB_CSR_IRQACK = 7;

	localparam int ASB_CW_GAIN_LSB = 0;
	localparam int ASB_CW_BLK_LSB = 3;
	localparam int ASB_CW_RATE_LSB = 7;
	localparam int ASB_CW_SINGLE = 11;
	localparam int ASB_CW_EXTSYNC = 12;

	localparam logic [15:0] ASB_CSR_RST = 16'h0000;
	localparam logic [15:0] ASB_CW_RST = 16'h0000;
	localparam logic [2:0] ASB_GAIN_MAX = 3'h4;

	localparam int ASB_CLK_HZ = 100000000;
	localparam int ASB_MAX_RATE_HZ = 125000;
	localparam int ASB_RATE_CYC = ASB_CLK_HZ / ASB_MAX_RATE_HZ;
	localparam int ASB_RATE_CNT_W = 25;
	localparam logic [24:0] ASB_RATE_CYC_V = 25'(ASB_RATE_CYC);

	typedef enum logic [2:0] {
		ASB_IDLE = 3'b001,
		ASB_RUN = 3'b010,
		ASB_DONE = 3'b100
	} asb_seq_t;
endpackage

/* File: src/asb_scan_ctrl.sv */
// Contract
// - Input samples go in order into two 64K-word input buffers.
// - One control word bit picks the input buffer mapped for host access.
// - Host control words set block length and input scan rate.
// - Input control word holds gain x1..x16, block length and preset rate.
// - If enabled, raise interrupt when an input block is full.
// - Scan events from preset rate or external sync, as configured.
// - Continuous mode runs until host stops; fill one, host reads other.
// - Single-block mode fills one block then stops input scanning.
// - Master board drives scan sync; slaves follow master sync.
// - After reset, host access to all buffers is blocked.
// - Only a control bit enables host buffer access; boards may share window.
// - Buffer window base set by jumpers, on 20000 hex word boundaries.
// - Program bit connects analog outputs on-line or isolates them.
// - Each output channel replays its own 64K-word output buffer.
// - Output sequencing works like input, independent of input scanning.
// - Block length field sets 2 to 64K words in power-of-two steps.
// - Address counter wraps to 0 with end-of-scan pulse at programmed length.
// - Memory arbiter priority: output, input, host, refresh.
// - Samples are written in channel order starting at channel 0; code has no channel select, stores in arrival order.
`timescale 1ns/1ps
`default_nettype none
module asb_scan_ctrl
	import asb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [asb_pkg::ASB_AW-1:0] reg_addr,
	input wire logic [asb_pkg::ASB_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [asb_pkg::ASB_DW-1:0] reg_rdata,
	input wire logic [asb_pkg::ASB_WIN_BASE_W-1:0] jumper_base,
	input wire logic [31:0] host_addr,
	input wire logic [asb_pkg::ASB_DW-1:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic host_sel,
	output logic [asb_pkg::ASB_DW-1:0] host_rdata,
	input wire logic adc_valid,
	input wire logic [asb_pkg::ASB_SAMPLE_W-1:0] adc_data,
	input wire logic ext_sync,
	input wire logic sync_in,
	output logic sync_out,
	output logic scan_trigger,
	output logic [asb_pkg::ASB_GAIN_W-1:0] gain_sel,
	output logic [asb_pkg::ASB_SAMPLE_W-1:0] dac0_data,
	output logic [asb_pkg::ASB_SAMPLE_W-1:0] dac1_data,
	output logic dac_update,
	output logic out_online,
	output logic end_scan_in,
	output logic end_scan_out,
	output logic irq,
	input wire logic refresh_req,
	output logic refresh_gnt
);
	import asb_pkg::*;

	logic [15:0] board_control_status_word, icw, ocw;
	logic [ASB_SAMPLE_W-1:0] ibuf0 [ASB_BUF_WORDS];
	logic [ASB_SAMPLE_W-1:0] ibuf1 [ASB_BUF_WORDS];
	logic [ASB_SAMPLE_W-1:0] obuf0 [ASB_BUF_WORDS];
	logic [ASB_SAMPLE_W-1:0] obuf1 [ASB_BUF_WORDS];

	function automatic logic [16:0] blk_words(input logic [3:0] code);
		logic [4:0] sh;
		sh = 5'(code) + 5'h01;
		blk_words = 17'h00001 << sh;
	endfunction

	function automatic logic [ASB_RATE_CNT_W-1:0] rate_div(input logic [3:0] code);
		rate_div = ASB_RATE_CYC_V << code;
	endfunction

	// Pin synchronisers, three stages each
	logic [2:0] ext_s, mst_s;
	logic ext_lvl, mst_lvl;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_s <= 3'h0;
			mst_s <= 3'h0;
			ext_lvl <= 1'b0;
			mst_lvl <= 1'b0;
		end else begin
			ext_s <= {ext_s[1:0], ext_sync};
			mst_s <= {mst_s[1:0], sync_in};
			if (ext_s[1] == ext_s[2]) ext_lvl <= ext_s[2];
			if (mst_s[1] == mst_s[2]) mst_lvl <= mst_s[2];
		end
	end
	logic ext_d, mst_d;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_d <= 1'b0;
			mst_d <= 1'b0;
		end else begin
			ext_d <= ext_lvl;
			mst_d <= mst_lvl;
		end
	end
	wire ext_rise = ext_lvl & ~ext_d;
	wire mst_rise = mst_lvl & ~mst_d;

	// Register port
	wire is_master = board_control_status_word[ASB_CSR_MASTER];
	wire wr_csr = reg_wr && reg_addr == ASB_OFF_BCSW;
	wire wr_icw = reg_wr && reg_addr == ASB_OFF_ISCW;
	wire wr_ocw = reg_wr && reg_addr == ASB_OFF_OSCW;
	logic irq_flag, in_fill, in_cmpl, out_cmpl;
	asb_seq_t ist, ost;
	wire irq_set;
	wire irq_clr = wr_csr && reg_wdata[ASB_CSR_IRQACK];
	wire [15:0] stat_word = {10'h000, ost == ASB_RUN, ist == ASB_RUN, out_cmpl, in_cmpl, in_fill, irq_flag};
	wire [15:0] rd_mux = reg_addr == ASB_OFF_BCSW ? board_control_status_word :
		reg_addr == ASB_OFF_ISCW ? icw :
		reg_addr == ASB_OFF_OSCW ? ocw :
		reg_addr == ASB_OFF_STAT ? stat_word : 16'h0000;

	logic in_stop, out_stop;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			board_control_status_word <= ASB_CSR_RST;
			icw <= ASB_CW_RST;
			ocw <= ASB_CW_RST;
			reg_rdata <= 16'h0000;
		end else begin
			if (wr_csr) board_control_status_word <= reg_wdata & 16'h007f;
			else begin
				if (in_stop) board_control_status_word[ASB_CSR_IRUN] <= 1'b0;
				if (out_stop) board_control_status_word[ASB_CSR_ORUN] <= 1'b0;
			end
			if (wr_icw) icw <= reg_wdata;
			if (wr_ocw) ocw <= reg_wdata;
			if (reg_rd) reg_rdata <= rd_mux;
		end
	end
	wire [2:0] gain_field = icw[ASB_CW_GAIN_LSB +: ASB_GAIN_W];
	assign gain_sel = gain_field > ASB_GAIN_MAX ? ASB_GAIN_MAX : gain_field;
	assign out_online = board_control_status_word[ASB_CSR_ONLINE];

	// Scan event generators
	logic [ASB_RATE_CNT_W-1:0] icnt, ocnt;
	wire [ASB_RATE_CNT_W-1:0] idiv = rate_div(icw[ASB_CW_RATE_LSB +: ASB_RATE_W]);
	wire [ASB_RATE_CNT_W-1:0] odiv = rate_div(ocw[ASB_CW_RATE_LSB +: ASB_RATE_W]);
	wire itick_int = icnt >= idiv - 25'h0000001;
	wire otick_int = ocnt >= odiv - 25'h0000001;
	wire isrc = icw[ASB_CW_EXTSYNC] ? ext_rise : itick_int;
	wire osrc = ocw[ASB_CW_EXTSYNC] ? ext_rise : otick_int;
	wire iev = is_master ? isrc : mst_rise;
	wire oev = is_master ? osrc : mst_rise;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			icnt <= 25'h0000000;
			ocnt <= 25'h0000000;
			sync_out <= 1'b0;
		end else begin
			icnt <= itick_int ? 25'h0000000 : icnt + 25'h0000001;
			ocnt <= otick_int ? 25'h0000000 : ocnt + 25'h0000001;
			sync_out <= is_master & isrc & (ist == ASB_RUN);
		end
	end
	assign scan_trigger = (ist == ASB_RUN) & iev;

	// Arbiter: output, input, host, refresh
	logic out_pend, in_pend;
	logic [ASB_SAMPLE_W-1:0] in_pend_data;
	wire host_hit = board_control_status_word[ASB_CSR_BUFEN] && host_addr[31:ASB_WIN_AW] == jumper_base;
	wire g_out = out_pend;
	wire g_in = ~g_out & in_pend;
	wire g_host = ~g_out & ~g_in & host_hit & (host_wr | host_rd);
	assign refresh_gnt = ~g_out & ~g_in & ~g_host & refresh_req;

	// Input sequencer
	logic [16:0] iaddr;
	wire [16:0] ilen = blk_words(icw[ASB_CW_BLK_LSB +: ASB_BLK_W]);
	wire iblk_end = g_in && (iaddr + 17'h00001 == ilen);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ist <= ASB_IDLE;
			iaddr <= 17'h00000;
			in_fill <= 1'b0;
			in_pend <= 1'b0;
			in_pend_data <= 12'h000;
			end_scan_in <= 1'b0;
			in_stop <= 1'b0;
		end else begin
			end_scan_in <= 1'b0;
			in_stop <= 1'b0;
			if (adc_valid && ist == ASB_RUN) begin
				in_pend <= 1'b1;
				in_pend_data <= adc_data;
			end else if (g_in) in_pend <= 1'b0;
			if (g_in) begin
				if (in_fill) ibuf1[iaddr[15:0]] <= in_pend_data;
				else ibuf0[iaddr[15:0]] <= in_pend_data;
				iaddr <= iblk_end ? 17'h00000 : iaddr + 17'h00001;
			end
			case (ist)
				ASB_IDLE: begin
					if (board_control_status_word[ASB_CSR_IRUN]) begin
						ist <= ASB_RUN;
						iaddr <= 17'h00000;
						in_fill <= ~board_control_status_word[ASB_CSR_BUFSEL];
					end
				end
				ASB_RUN: begin
					if (iblk_end) begin
						end_scan_in <= 1'b1;
						if (icw[ASB_CW_SINGLE]) begin
							ist <= ASB_DONE;
							in_stop <= 1'b1;
						end else in_fill <= ~in_fill;
					end else if (!board_control_status_word[ASB_CSR_IRUN]) ist <= ASB_IDLE;
				end
				ASB_DONE: begin
					if (!board_control_status_word[ASB_CSR_IRUN]) ist <= ASB_IDLE;
				end
				default: ist <= ASB_IDLE;
			endcase
		end
	end

	// Completion flags, set wins over clear
	assign irq_set = end_scan_in & board_control_status_word[ASB_CSR_IRQEN];
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_flag <= 1'b0;
			in_cmpl <= 1'b0;
			out_cmpl <= 1'b0;
		end else begin
			irq_flag <= irq_set | (irq_flag & ~irq_clr);
			in_cmpl <= end_scan_in | (in_cmpl & ~irq_clr);
			out_cmpl <= end_scan_out | (out_cmpl & ~irq_clr);
		end
	end
	assign irq = irq_flag & board_control_status_word[ASB_CSR_IRQEN];

	// Output sequencer, independent of input side
	logic [16:0] oaddr;
	wire [16:0] olen = blk_words(ocw[ASB_CW_BLK_LSB +: ASB_BLK_W]);
	wire oblk_end = g_out && (oaddr + 17'h00001 == olen);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ost <= ASB_IDLE;
			oaddr <= 17'h00000;
			out_pend <= 1'b0;
			dac0_data <= 12'h000;
			dac1_data <= 12'h000;
			dac_update <= 1'b0;
			end_scan_out <= 1'b0;
			out_stop <= 1'b0;
		end else begin
			dac_update <= g_out;
			end_scan_out <= 1'b0;
			out_stop <= 1'b0;
			if (ost == ASB_RUN && oev) out_pend <= 1'b1;
			else if (g_out) out_pend <= 1'b0;
			if (g_out) begin
				dac0_data <= obuf0[oaddr[15:0]];
				dac1_data <= obuf1[oaddr[15:0]];
				oaddr <= oblk_end ? 17'h00000 : oaddr + 17'h00001;
			end
			case (ost)
				ASB_IDLE: begin
					if (board_control_status_word[ASB_CSR_ORUN]) begin
						ost <= ASB_RUN;
						oaddr <= 17'h00000;
					end
				end
				ASB_RUN: begin
					if (oblk_end) begin
						end_scan_out <= 1'b1;
						if (ocw[ASB_CW_SINGLE]) begin
							ost <= ASB_DONE;
							out_stop <= 1'b1;
						end
					end else if (!board_control_status_word[ASB_CSR_ORUN]) ost <= ASB_IDLE;
				end
				ASB_DONE: begin
					if (!board_control_status_word[ASB_CSR_ORUN]) ost <= ASB_IDLE;
				end
				default: ost <= ASB_IDLE;
			endcase
		end
	end

	// Host window: lower half is the selected input buffer, upper half the selected output buffer
	wire hreg_out = host_addr[16];
	wire [15:0] hoff = host_addr[15:0];
	wire hsel_b1 = board_control_status_word[ASB_CSR_BUFSEL];
	wire [1:0] hreg = {hreg_out, hsel_b1};
	assign host_sel = host_hit;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			host_rdata <= 16'h0000;
		end else if (g_host) begin
			if (host_wr) begin
				if (hreg == 2'h2) obuf0[hoff] <= host_wdata[11:0];
				if (hreg == 2'h3) obuf1[hoff] <= host_wdata[11:0];
			end
			if (host_rd) begin
				case (hreg)
					2'h0: host_rdata <= {{4{ibuf0[hoff][11]}}, ibuf0[hoff]};
					2'h1: host_rdata <= {{4{ibuf1[hoff][11]}}, ibuf1[hoff]};
					2'h2: host_rdata <= {{4{obuf0[hoff][11]}}, obuf0[hoff]};
					default: host_rdata <= {{4{obuf1[hoff][11]}}, obuf1[hoff]};
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/asb_scan_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module asb_checker
	import asb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [14:0] jumper_base,
	input wire logic [31:0] host_addr,
	input wire logic host_sel,
	input wire logic [2:0] gain_sel,
	input wire logic [11:0] dac0_data,
	input wire logic dac_update,
	input wire logic out_online,
	input wire logic end_scan_in,
	input wire logic scan_trigger
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	sequence bcsw_wr;
		reg_wr && reg_addr == ASB_OFF_BCSW;
	endsequence
	a_window_match: assert property (
		host_sel |-> host_addr[31:17] == jumper_base) else $error("host select outside window");
	a_online_follow: assert property (
		bcsw_wr |=> out_online == $past(reg_wdata[ASB_CSR_ONLINE])) else $error("online bit not applied");
	a_gain_range: assert property (
		gain_sel <= ASB_GAIN_MAX) else $error("gain out of range");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr > ASB_OFF_STAT |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
	a_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
	a_end_pulse: assert property (
		end_scan_in |=> !end_scan_in) else $error("end of scan not a pulse");
	a_trig_pulse: assert property (
		scan_trigger |=> !scan_trigger) else $error("scan trigger not a pulse");
	a_dac_new: assert property (
		$changed(dac0_data) |-> (dac_update || $past(dac_update))) else $error("output moved without update");
endmodule
bind asb_scan_ctrl asb_checker asb_checker_i(.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .jumper_base, .host_addr, .host_sel, .gain_sel, .dac0_data, .dac_update, .out_online,
	.end_scan_in, .scan_trigger);
`default_nettype wire

/* File: tb/asb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asb_host_model (
	input wire logic clk_sys,
	input wire logic host_sel,
	input wire logic [15:0] host_rdata,
	output logic [31:0] host_addr,
	output logic [15:0] host_wdata,
	output logic host_wr,
	output logic host_rd
);
	initial begin
		host_addr = 32'h0000_0000;
		host_wdata = 16'h0000;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	// One access; a released bus shows inverted values
	task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d, output logic [15:0] q,
		output logic s);
		@(posedge clk_sys);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= w;
		host_rd <= !w;
		@(posedge clk_sys);
		s = host_sel;
		host_addr <= ~a;
		host_wdata <= ~d;
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		@(posedge clk_sys);
		q = host_rdata;
	endtask
endmodule
`default_nettype wire

/* File: tb/asb_scan_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module asb_scan_ctrl_test;
	import asb_pkg::*;
	logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, adc_valid = 0, s;
	logic ext_sync = 0, sync_in = 0, refresh_req = 0, sync_out, refresh_gnt, end_scan_out;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, host_wdata, host_rdata, q;
	logic [11:0] adc_data = 12'h000, dac0_data, dac1_data;
	logic [31:0] host_addr, base;
	logic [14:0] jumper_base = 15'h0123;
	logic [2:0] gain_sel;
	logic host_wr, host_rd, host_sel, scan_trigger, dac_update, out_online, end_scan_in, irq;
	int fail_count = 0, tests_run = 0, cycles = 0, n;
	asb_scan_ctrl asb_scan_ctrl_i(.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.jumper_base, .host_addr, .host_wdata, .host_wr, .host_rd, .host_sel, .host_rdata, .adc_valid,
		.adc_data, .ext_sync, .sync_in, .sync_out, .scan_trigger, .gain_sel, .dac0_data,
		.dac1_data, .dac_update, .out_online, .end_scan_in, .end_scan_out, .irq, .refresh_req,
		.refresh_gnt);
	asb_host_model asb_host_model_i(.clk_sys, .host_sel, .host_rdata, .host_addr, .host_wdata, .host_wr,
		.host_rd);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic adc(input logic [11:0] d);
		@(posedge clk_sys);
		adc_valid <= 1'b1;
		adc_data <= d;
		@(posedge clk_sys);
		adc_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rd(i[3:0], q);
			chk(q, 16'h0000);
		end
		asb_host_model_i.acc(1'b0, base, 16'h0000, q, s);
		chk(s, 1'b0);
	endtask
	task automatic t_regs();
		wr(ASB_OFF_BCSW, 16'h0004);
		chk(out_online, 1'b1);
		for (int g = 0; g < 8; g++) begin
			wr(ASB_OFF_ISCW, 16'(g));
			chk(gain_sel, (g > 4) ? 16'h4 : 16'(g));
		end
		wr(ASB_OFF_ISCW, 16'h1d5b);
		rd(ASB_OFF_ISCW, q);
		chk(q, 16'h1d5b);
		wr(4'hf, 16'hffff);
		rd(4'hf, q);
		chk(q, 16'h0000);
	endtask
	task automatic t_scan();
		wr(ASB_OFF_ISCW, 16'h0800);
		wr(ASB_OFF_BCSW, 16'h005a);
		for (n = 0; n < 2000 && scan_trigger !== 1'b1; n++) @(posedge clk_sys);
		chk(scan_trigger, 1'b1);
		adc(12'h801);
		adc(12'h123);
		chk(irq, 1'b1);
		rd(ASB_OFF_STAT, q);
		chk(q & 16'h0015, 16'h0005);
		n = 0;
		repeat (900) @(posedge clk_sys) n += (scan_trigger !== 1'b0);
		chk(n, 0);
		wr(ASB_OFF_BCSW, 16'h008b);
		chk(irq, 1'b0);
		asb_host_model_i.acc(1'b0, base, 16'h0000, q, s);
		chk(s, 1'b1);
		chk(q, 16'hf801);
		asb_host_model_i.acc(1'b0, base + 1, 16'h0000, q, s);
		chk(q, 16'h0123);
	endtask
	task automatic t_out();
		wr(ASB_OFF_BCSW, 16'h0002);
		asb_host_model_i.acc(1'b1, base + 32'h10000, 16'h05a5, q, s);
		chk(s, 1'b1);
		wr(ASB_OFF_BCSW, 16'h0003);
		asb_host_model_i.acc(1'b1, base + 32'h10000, 16'h03c3, q, s);
		asb_host_model_i.acc(1'b0, base + 32'h10000, 16'h0000, q, s);
		chk(q, 16'h03c3);
		wr(ASB_OFF_OSCW, 16'h0800);
		wr(ASB_OFF_BCSW, 16'h0066);
		for (n = 0; n < 2000 && dac_update !== 1'b1; n++) @(posedge clk_sys);
		chk(dac0_data, 12'h5a5);
		chk(dac1_data, 12'h3c3);
		for (n = 0; n < 2000 && end_scan_out !== 1'b1; n++) @(posedge clk_sys);
		chk(end_scan_out, 1'b1);
		rd(ASB_OFF_STAT, q);
		chk(q & 16'h0028, 16'h0008);
	endtask
	task automatic t_sync();
		wr(ASB_OFF_ISCW, 16'h1000);
		wr(ASB_OFF_BCSW, 16'h0050);
		n = 0;
		repeat (900) @(posedge clk_sys) n += (scan_trigger !== 1'b0);
		chk(n, 0);
		ext_sync <= 1'b1;
		for (n = 0; n < 10 && scan_trigger !== 1'b1; n++) @(posedge clk_sys);
		chk(scan_trigger, 1'b1);
		@(posedge clk_sys);
		chk(sync_out, 1'b1);
		adc(12'h011);
		adc(12'h022);
		rd(ASB_OFF_STAT, q);
		chk(q & 16'h0012, 16'h0010);
		wr(ASB_OFF_BCSW, 16'h0010);
		sync_in <= 1'b1;
		for (n = 0; n < 10 && scan_trigger !== 1'b1; n++) @(posedge clk_sys);
		chk(scan_trigger, 1'b1);
		chk(sync_out, 1'b0);
		wr(ASB_OFF_BCSW, 16'h0000);
		refresh_req <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(refresh_gnt, 1'b1);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		base = {jumper_base, 17'h00000};
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_regs();
		t_scan();
		t_out();
		t_sync();
		tally_and_finish();
	end
endmodule
`default_nettype wire
